// ===== rtl/mmt_timer.sv
// 16-bit multimode timer: event count, pwm, capture, difference capture
`timescale 1ns/1ps
`include "mmt_regs.svh"

// Operation
// - holds 16-bit counter, two 16-bit reload registers, 8-bit control
// - each 16-bit register is reached as high and low byte
// - reset: counter all ones, reloads zero, control zero
// - bit 4 starts and stops the timer outside capture modes
// - running counter decrements once per timer clock
// - underflow steps from zero to all ones or reload value
// - bit 2 enables the interrupt; source is underflow or capture
// - bit 3 is the interrupt pending flag
// - in capture modes bit 4 is the underflow pending flag
// - bit 1 picks pulse (0) or cycle (1) capture
// - pwm bit 0 alternates primary and secondary reload, primary first
// - bits 7..5 select the operating mode
// - modes 000/001 count rising/falling pin edges, interrupt on underflow
// - modes 10x pwm on instruction clock; low mode bit toggles pin
// - modes 010/011 capture on rising/falling pin edge
// - modes 11x capture difference between selected edge pairs
// - one shared pin; direction follows the mode
// - pwm underflow reloads from selected register and sets pending
// - interrupt only with enable bit and global enable both set
// - pin edges sensed up to half instruction clock rate
// - event underflow reloads from primary register only
module mmt_timer #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // core memory access and interrupt
   input wire mmt_pkg::mmt_bus_t bus,
   output logic [7:0] rdata,
   input wire logic global_irq_en,
   output logic timer_interrupt,
   // shared port pin
   input wire logic timer_pin_in,
   output logic timer_pin_out,
   output logic timer_pin_oe
);
   import mmt_pkg::*;

   if (CNT_W != 16) begin : g_chk
      $error("counter must be two bytes wide");
   end

   logic [CNT_W-1:0] down_counter, next_down_counter;
   logic [CNT_W-1:0] reload_capture_a, next_reload_capture_a;
   logic [CNT_W-1:0] reload_secondary, next_reload_secondary;
   logic [CNT_W-1:0] snap, next_snap;
   logic [7:0] timer_control, next_timer_control;
   logic [7:0] next_rdata;
   logic sel_b, next_sel_b;
   mmt_dif_t dif, next_dif;
   logic s1, s2, s3, lvl, next_lvl;
   logic next_irq, next_pin_out, next_oe;
   logic rise, fall, dec, uf, pnd_set, uf_set, e1, e2;
   logic cap_hit;
   mmt_mode_t mode;

   function automatic logic pick_edge(logic fall_sel, logic r, logic f);
      return fall_sel ? f : r;
   endfunction

   function automatic logic is_pwm(mmt_mode_t m);
      return m == MMT_PWM_HOLD || m == MMT_PWM_TOG;
   endfunction

   function automatic logic is_cap(mmt_mode_t m);
      return m[1];
   endfunction

   function automatic logic hit(mmt_bus_t b, logic [7:0] a);
      return b.wr && b.addr == a;
   endfunction

   assign mode = mmt_mode_t'(timer_control[7:`MMT_MODE_LSB]);

   // pin level taken once the second and third stage agree
   always_comb begin
      next_lvl = (s2 == s3) ? s3 : lvl;
      rise = (s2 == s3) && s3 && !lvl;
      fall = (s2 == s3) && !s3 && lvl;
   end

   always_comb begin
      next_down_counter = down_counter;
      next_reload_capture_a = reload_capture_a;
      next_reload_secondary = reload_secondary;
      next_snap = snap;
      next_sel_b = sel_b;
      next_dif = dif;
      next_pin_out = timer_pin_out;
      pnd_set = 1'b0;
      uf_set = 1'b0;
      cap_hit = 1'b0;
      e1 = pick_edge(mode[0], rise, fall);
      e2 = pick_edge(mode[0] ^ !timer_control[`MMT_BIT_CAPTYPE], rise,
         fall);
      case (mode)
         MMT_EVT_RISE, MMT_EVT_FALL:
            dec = timer_control[`MMT_BIT_RUN] && e1;
         MMT_PWM_HOLD, MMT_PWM_TOG:
            dec = timer_control[`MMT_BIT_RUN];
         default:
            dec = 1'b1; // capture modes free-run
      endcase
      uf = dec && down_counter == '0;
      if (dec) begin
         next_down_counter = down_counter - 1'b1;
      end
      if (uf) begin
         if (is_cap(mode)) begin
            next_down_counter = `MMT_RST_CNT;
            uf_set = 1'b1;
         end else if (is_pwm(mode)) begin
            next_down_counter = sel_b ? reload_secondary
               : reload_capture_a;
            next_sel_b = timer_control[`MMT_BIT_DUAL] && !sel_b;
            pnd_set = 1'b1;
            if (mode == MMT_PWM_TOG) begin
               next_pin_out = !timer_pin_out;
            end
         end else begin
            next_down_counter = reload_capture_a;
            pnd_set = 1'b1;
         end
      end
      // stopped or single-reload pwm restarts on the primary value
      if (!is_pwm(mode) || !timer_control[`MMT_BIT_RUN]
         || !timer_control[`MMT_BIT_DUAL]) begin
         next_sel_b = 1'b0;
      end
      if (mode == MMT_CAP_RISE || mode == MMT_CAP_FALL) begin
         if (e1) begin
            next_reload_capture_a = down_counter;
            pnd_set = 1'b1;
            cap_hit = 1'b1;
         end
      end
      case (dif)
         MMT_DIF_ARM: begin
            if (mode[2] && mode[1] && e1) begin
               next_snap = down_counter;
               next_dif = MMT_DIF_WAIT;
            end
         end
         MMT_DIF_WAIT: begin
            if (!(mode[2] && mode[1])) begin
               next_dif = MMT_DIF_ARM;
            end else if (e2) begin
               // counter runs down, so elapsed time is start minus now
               next_reload_capture_a = snap - down_counter;
               pnd_set = 1'b1;
               cap_hit = 1'b1;
               next_snap = down_counter;
               // cycle capture reuses the closing edge as the next start
               next_dif = timer_control[`MMT_BIT_CAPTYPE] ? MMT_DIF_WAIT
                  : MMT_DIF_ARM;
            end
         end
         default: next_dif = MMT_DIF_ARM;
      endcase
      // byte writes; a hardware capture into the primary wins
      if (hit(bus, `MMT_OFS_CNT_LO)) begin
         next_down_counter[7:0] = bus.wdata;
      end
      if (hit(bus, `MMT_OFS_CNT_HI)) begin
         next_down_counter[15:8] = bus.wdata;
      end
      if (!cap_hit) begin
         if (hit(bus, `MMT_OFS_RA_LO)) begin
            next_reload_capture_a[7:0] = bus.wdata;
         end
         if (hit(bus, `MMT_OFS_RA_HI)) begin
            next_reload_capture_a[15:8] = bus.wdata;
         end
      end
      if (hit(bus, `MMT_OFS_RB_LO)) begin
         next_reload_secondary[7:0] = bus.wdata;
      end
      if (hit(bus, `MMT_OFS_RB_HI)) begin
         next_reload_secondary[15:8] = bus.wdata;
      end
   end

   always_comb begin
      next_timer_control = hit(bus, `MMT_OFS_CTRL) ? bus.wdata
         : timer_control;
      // a flag set by hardware beats a clear in the same cycle
      next_timer_control[`MMT_BIT_PND] =
         next_timer_control[`MMT_BIT_PND] | pnd_set;
      next_timer_control[`MMT_BIT_RUN] =
         next_timer_control[`MMT_BIT_RUN] | uf_set;
      next_irq = global_irq_en && timer_control[`MMT_BIT_IEN]
         && (timer_control[`MMT_BIT_PND]
         || (is_cap(mode) && timer_control[`MMT_BIT_RUN]));
      next_oe = is_pwm(mode);
      next_rdata = rdata;
      if (bus.rd) begin
         case (bus.addr)
            `MMT_OFS_CNT_LO: next_rdata = down_counter[7:0];
            `MMT_OFS_CNT_HI: next_rdata = down_counter[15:8];
            `MMT_OFS_RA_LO: next_rdata = reload_capture_a[7:0];
            `MMT_OFS_RA_HI: next_rdata = reload_capture_a[15:8];
            `MMT_OFS_RB_LO: next_rdata = reload_secondary[7:0];
            `MMT_OFS_RB_HI: next_rdata = reload_secondary[15:8];
            `MMT_OFS_CTRL: next_rdata = timer_control;
            default: next_rdata = `MMT_READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         down_counter <= `MMT_RST_CNT;
         reload_capture_a <= `MMT_RST_RELOAD;
         reload_secondary <= `MMT_RST_RELOAD;
         timer_control <= `MMT_RST_CTRL;
         snap <= '0;
         sel_b <= 1'b0;
         dif <= MMT_DIF_ARM;
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         lvl <= 1'b0;
         rdata <= `MMT_READ_IDLE;
         timer_interrupt <= 1'b0;
         timer_pin_out <= 1'b0;
         timer_pin_oe <= 1'b0;
      end else begin
         down_counter <= next_down_counter;
         reload_capture_a <= next_reload_capture_a;
         reload_secondary <= next_reload_secondary;
         timer_control <= next_timer_control;
         snap <= next_snap;
         sel_b <= next_sel_b;
         dif <= next_dif;
         s1 <= timer_pin_in;
         s2 <= s1;
         s3 <= s2;
         lvl <= next_lvl;
         rdata <= next_rdata;
         timer_interrupt <= next_irq;
         timer_pin_out <= next_pin_out;
         timer_pin_oe <= next_oe;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic wr_cnt;
   assign wr_cnt = bus.wr && bus.addr[7:1] == 7'h56;

   rst_vals_a: assert property ($rose(rst_b) |->
      down_counter == 16'hFFFF && reload_capture_a == 16'h0000
      && timer_control == 8'h00) else $error("reset values wrong");
   pwm_dec_a: assert property (is_pwm(mode) && timer_control[4]
      && down_counter != 16'h0000 && !wr_cnt
      |=> down_counter == $past(down_counter) - 16'h0001)
      else $error("pwm counter did not step down");
   stop_hold_a: assert property (is_pwm(mode) && !timer_control[4]
      && !wr_cnt |=> $stable(down_counter))
      else $error("stopped counter moved");
   pwm_reload_a: assert property (is_pwm(mode) && timer_control[4]
      && down_counter == 16'h0000 && !sel_b && !wr_cnt
      |=> down_counter == $past(reload_capture_a) && timer_control[3])
      else $error("pwm underflow reload wrong");
   dual_alt_a: assert property (is_pwm(mode) && timer_control[4]
      && down_counter == 16'h0000 && sel_b && !wr_cnt
      |=> down_counter == $past(reload_secondary))
      else $error("secondary reload missed");
   toggle_a: assert property (mode == MMT_PWM_TOG && timer_control[4]
      && down_counter == 16'h0000 |=> timer_pin_out != $past(timer_pin_out))
      else $error("pin not toggled on underflow");
   irq_gate_a: assert property (timer_interrupt |->
      $past(global_irq_en) && $past(timer_control[2]))
      else $error("interrupt without both enables");
   evt_hold_a: assert property (!mode[2] && !mode[1] && !wr_cnt
      && !(rise || fall) |=> $stable(down_counter))
      else $error("event counter moved without edge");
   evt_reload_a: assert property (!mode[2] && !mode[1] && e1
      && timer_control[4] && down_counter == 16'h0000 && !wr_cnt
      |=> down_counter == $past(reload_capture_a) && timer_control[3])
      else $error("event underflow reload wrong");
   cap_copy_a: assert property (mode[1] && !mode[2] && e1
      |=> reload_capture_a == $past(down_counter) && timer_control[3])
      else $error("capture not stored");
   cap_uf_a: assert property (is_cap(mode) && !wr_cnt
      && down_counter == 16'h0000
      |=> down_counter == 16'hFFFF && timer_control[4])
      else $error("capture underflow not flagged");
   dif_calc_a: assert property (dif == MMT_DIF_WAIT && mode[2]
      && mode[1] && e2 |=> timer_control[3]
      && reload_capture_a == $past(snap) - $past(down_counter))
      else $error("difference capture wrong");
   oe_mode_a: assert property (##1
      timer_pin_oe == $past(is_pwm(mode)))
      else $error("pin direction wrong");

   pwm_uf_c: cover property (is_pwm(mode) && uf);
   dual_c: cover property (is_pwm(mode) && uf && sel_b);
   evt_uf_c: cover property (!mode[2] && !mode[1] && uf);
   dif_cap_c: cover property (dif == MMT_DIF_WAIT && mode[2] && e2);
   irq_c: cover property ($rose(timer_interrupt));
endmodule // mmt_timer

// ===== rtl/mmt_regs.svh
// register offsets, control fields and reset values of the 16-bit timer
`ifndef MMT_REGS_SVH
`define MMT_REGS_SVH
`define MMT_OFS_RB_LO 8'hA7
`define MMT_OFS_RB_HI 8'hA8
`define MMT_OFS_RA_LO 8'hAA
`define MMT_OFS_RA_HI 8'hAB
`define MMT_OFS_CNT_LO 8'hAC
`define MMT_OFS_CNT_HI 8'hAD
`define MMT_OFS_CTRL 8'hAE
`define MMT_BIT_DUAL 0
`define MMT_BIT_CAPTYPE 1
`define MMT_BIT_IEN 2
`define MMT_BIT_PND 3
`define MMT_BIT_RUN 4
`define MMT_MODE_LSB 5
`define MMT_RST_CNT 16'hFFFF
`define MMT_RST_RELOAD 16'h0000
`define MMT_RST_CTRL 8'h00
`define MMT_READ_IDLE 8'h00
`endif

// ===== rtl/mmt_pkg.sv
// types of the 16-bit multimode timer
package mmt_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } mmt_bus_t;
   typedef enum logic [2:0] {
      MMT_EVT_RISE = 3'b000,
      MMT_EVT_FALL = 3'b001,
      MMT_CAP_RISE = 3'b010,
      MMT_CAP_FALL = 3'b011,
      MMT_PWM_HOLD = 3'b100,
      MMT_PWM_TOG = 3'b101,
      MMT_DIF_RISE = 3'b110,
      MMT_DIF_FALL = 3'b111
   } mmt_mode_t;
   typedef enum logic {
      MMT_DIF_ARM = 1'b0,
      MMT_DIF_WAIT = 1'b1
   } mmt_dif_t;
endpackage

// ===== bench/mmt_pin_src.sv
// external source on the shared timer pin
`timescale 1ns/1ps
module mmt_pin_src (
   // clock
   input wire logic clk,
   // pin
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_in
);
   logic ext_lvl;
   initial ext_lvl = 1'b0;
   // a driven pin reads back its own level
   assign pin_in = pin_oe ? pin_out : ext_lvl;
   // each pulse lasts 3 clocks and the level between pulses 4, slower than the half-rate limit
   task automatic pulse(input int n);
      repeat (n) begin
         @(negedge clk) ext_lvl = ~ext_lvl;
         repeat (3) @(negedge clk);
         ext_lvl = ~ext_lvl;
         repeat (3) @(negedge clk);
      end
      // room for the input synchroniser
      repeat (4) @(negedge clk);
   endtask
endmodule // mmt_pin_src

// ===== bench/mmt_timer_tb.sv
// self-checking bench of the 16-bit multimode timer
`timescale 1ns/1ps
module mmt_timer_tb;
   import mmt_pkg::*;
   logic clk, rst_b, gie, irq, p_in, p_out, p_oe;
   logic [7:0] rdata, v;
   mmt_bus_t bus;
   int n_fail = 0;
   int compares = 0;
   mmt_timer dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
      .global_irq_en(gie), .timer_interrupt(irq), .timer_pin_in(p_in),
      .timer_pin_out(p_out), .timer_pin_oe(p_oe));
   mmt_pin_src src (.clk(clk), .pin_out(p_out), .pin_oe(p_oe),
      .pin_in(p_in));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic tally_and_finish;
      if (n_fail == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      bus.addr = a;
      bus.wdata = d;
      bus.wr = 1'b1;
      @(negedge clk);
      bus.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      bus.addr = a;
      bus.rd = 1'b1;
      @(negedge clk);
      bus.rd = 1'b0;
      d = rdata;
   endtask
   task automatic t_regs;
      logic [7:0] adr [8] = '{8'hA7, 8'hA8, 8'hAA, 8'hAB, 8'hAC, 8'hAD,
         8'hAE, 8'hA9};
      logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
         8'h00, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(adr[i], v);
         chk(v, rv[i]);
      end
      wr(8'hAA, 8'h5A);
      wr(8'hAB, 8'hA5);
      wr(8'hA8, 8'h3C);
      wr(8'hA9, 8'h77);
      rd(8'hAA, v);
      chk(v, 8'h5A);
      rd(8'hAB, v);
      chk(v, 8'hA5);
      rd(8'hA8, v);
      chk(v, 8'h3C);
      rd(8'hA9, v);
      chk(v, 8'h00);
   endtask
   task automatic t_event;
      wr(8'hAC, 8'h05);
      wr(8'hAD, 8'h00);
      wr(8'hAA, 8'h09);
      wr(8'hAB, 8'h00);
      wr(8'hAE, 8'h10);
      src.pulse(3);
      wr(8'hAE, 8'h00);
      rd(8'hAC, v);
      chk(v, 8'h02);
      wr(8'hAC, 8'h00);
      wr(8'hAE, 8'h10);
      src.pulse(1);
      rd(8'hAC, v);
      chk(v, 8'h09);
      rd(8'hAE, v);
      chk(v, 8'h18);
      wr(8'hAE, 8'h30);
      src.pulse(1);
      wr(8'hAE, 8'h20);
      rd(8'hAC, v);
      chk(v, 8'h08);
      rd(8'hAE, v);
      chk(v, 8'h20);
   endtask
   task automatic t_pwm;
      wr(8'hAC, 8'h02);
      wr(8'hAD, 8'h00);
      wr(8'hAA, 8'h02);
      wr(8'hAE, 8'hB0);
      for (int i = 0; i < 12 && p_out !== 1'b1; i++) @(negedge clk);
      chk1(p_out, 1'b1);
      chk1(p_oe, 1'b1);
      rd(8'hAE, v);
      chk(v, 8'hB8);
      rd(8'hAD, v);
      chk(v, 8'h00);
      gie = 1'b1;
      wr(8'hAE, 8'hBC);
      repeat (2) @(negedge clk);
      chk1(irq, 1'b1);
      gie = 1'b0;
      repeat (2) @(negedge clk);
      chk1(irq, 1'b0);
      wr(8'hAE, 8'h00);
      repeat (2) @(negedge clk);
      chk1(p_oe, 1'b0);
   endtask
   task automatic t_dual;
      logic p0;
      p0 = p_out;
      wr(8'hAC, 8'h00);
      wr(8'hAD, 8'h00);
      wr(8'hAA, 8'h03);
      wr(8'hA7, 8'h05);
      wr(8'hA8, 8'h00);
      // primary 3 at the first underflow, secondary 5 four clocks later
      wr(8'hAE, 8'h91);
      repeat (3) @(negedge clk);
      wr(8'hAE, 8'h80);
      rd(8'hAC, v);
      chk(v, 8'h05);
      rd(8'hAE, v);
      chk(v, 8'h88);
      chk1(p_out, p0);
      // leave pwm so the pin reads the source again before capture
      wr(8'hAE, 8'h00);
   endtask
   task automatic t_capture;
      wr(8'hAC, 8'hFF);
      wr(8'hAD, 8'hFF);
      wr(8'hAA, 8'h00);
      wr(8'hAB, 8'h00);
      wr(8'hAE, 8'h40);
      src.pulse(1);
      rd(8'hAE, v);
      chk(v, 8'h48);
      rd(8'hAB, v);
      chk(v, 8'hFF);
      wr(8'hAE, 8'hC0);
      src.pulse(1);
      rd(8'hAA, v);
      chk(v, 8'h03);
      rd(8'hAB, v);
      chk(v, 8'h00);
   endtask
   task automatic t_cycle;
      gie = 1'b1;
      wr(8'hAE, 8'h64);
      // counter reaches zero one clock after the high byte lands
      wr(8'hAC, 8'h03);
      wr(8'hAD, 8'h00);
      repeat (3) @(negedge clk);
      chk1(irq, 1'b1);
      rd(8'hAE, v);
      chk(v, 8'h74);
      src.pulse(1);
      rd(8'hAB, v);
      chk(v, 8'hFF);
      rd(8'hAE, v);
      chk(v, 8'h7C);
      gie = 1'b0;
      wr(8'hAE, 8'hE2);
      // falling edges of the source lie seven clocks apart
      src.pulse(2);
      rd(8'hAA, v);
      chk(v, 8'h07);
      rd(8'hAB, v);
      chk(v, 8'h00);
   endtask
   initial begin
      bus = '0;
      gie = 1'b0;
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      chk1(p_oe, 1'b0);
      t_regs();
      t_event();
      t_pwm();
      t_dual();
      t_capture();
      t_cycle();
      tally_and_finish();
   end
   // the tests need well under ten thousand clocks
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
endmodule // mmt_timer_tb
